// ### include/bpm_pkg.sv
// Constants, register map and carrier types for the bidirectional port block
package bpm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int PORT_W     = 8;
    localparam int SLOT_N     = 4;
    localparam int SLOT_IDX_W = 2;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_PIN_DATA  = 8'h00;   // port_pin_data
    localparam logic [7:0] OFS_DIR       = 8'h04;   // pin_direction_bits
    localparam logic [7:0] OFS_LATCH     = 8'h08;   // port_output_latch
    localparam logic [7:0] OFS_ANALOG    = 8'h0C;   // analog input select
    localparam logic [7:0] OFS_OWNED     = 8'h10;   // read only: peripheral owns pin
    localparam logic [7:0] OFS_OWNER_IDX = 8'h14;   // read only: winning slot per pin

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] DIR_RST    = 8'hFF;      // All pins input
    localparam logic [7:0] LATCH_RST  = 8'h00;
    localparam logic [7:0] ANALOG_RST = 8'h00;      // All pins digital

    ////////////////////////////////////////////////////////////////////////////
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Function slots present per pin, slot 0 ranks highest; order {pin7..pin0}
    localparam logic [7:0][3:0] SLOT_MASK_BASE = {4'h3, 4'h7, 4'h3, 4'h3,
                                                  4'h7, 4'h3, 4'h3, 4'h3};
    // Extra slots that exist only on the 28-pin variant (channel 3 outputs)
    localparam logic [7:0][3:0] SLOT_MASK_28   = {4'h4, 4'h8, 4'h0, 4'h0,
                                                  4'h0, 4'h0, 4'h0, 4'h0};

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin peripheral request bundle
    typedef struct packed {
        logic [3:0] en;     // Function enabled
        logic [3:0] drv;    // Function drives the pin (0 = input-type override)
        logic [3:0] dat;    // Value the function drives
    } bpm_pin_func_t;

endpackage

// ### src/bpm_port.sv
// Eight-bit bidirectional port with per-pin output priority mux and AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none

module bpm_port
    import bpm_pkg::*;
#(
    parameter int AXI_ADDR_W = 8,
    parameter int VARIANT_28 = 1
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [AXI_ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    input  wire logic                      s_axi_awvalid,
    output var  logic                      s_axi_awready,
    input  wire logic [AXI_DATA_W-1:0]     s_axi_wdata,
    input  wire logic [AXI_STRB_W-1:0]     s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output var  logic                      s_axi_wready,
    output var  logic [1:0]                s_axi_bresp,
    output var  logic                      s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    input  wire logic                      s_axi_arvalid,
    output var  logic                      s_axi_arready,
    output var  logic [AXI_DATA_W-1:0]     s_axi_rdata,
    output var  logic [1:0]                s_axi_rresp,
    output var  logic                      s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire bpm_pin_func_t [PORT_W-1:0] pin_funcs,
    input  wire logic [PORT_W-1:0]         port_pin_in,
    output var  logic [PORT_W-1:0]         port_pin_out,
    output var  logic [PORT_W-1:0]         port_pin_oe,
    output var  logic [PORT_W-1:0]         pin_digital_in,
    output var  logic [PORT_W-1:0]         pin_periph_owned
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (AXI_ADDR_W < 5 || AXI_ADDR_W > 32) begin : g_bad_addr_w
        $error("AXI_ADDR_W must lie between 5 and 32");
    end
    if (VARIANT_28 != 0 && VARIANT_28 != 1) begin : g_bad_variant
        $error("VARIANT_28 must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority encoder: bit 2 says found, low bits give the winning slot
    function automatic logic [SLOT_IDX_W:0] prio_pick(input logic [SLOT_N-1:0] req);
        logic [SLOT_IDX_W:0] pick;
        pick = 3'h0;
        // Walk from lowest rank up so the highest rank is written last
        for (int s = SLOT_N - 1; s >= 0; s--) begin
            if (req[s]) begin
                pick = {1'h1, s[SLOT_IDX_W-1:0]};
            end
        end
        return pick;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [PORT_W-1:0]     dir_ff;
    logic [PORT_W-1:0]     latch_ff;
    logic [PORT_W-1:0]     analog_ff;
    logic [PORT_W-1:0]     pin_out_ff;
    logic [PORT_W-1:0]     pin_oe_ff;
    logic [PORT_W-1:0]     dig_in_ff;
    logic [PORT_W-1:0]     owned_ff;
    logic [2*PORT_W-1:0]   owner_idx_ff;
    logic                  awready_ff;
    logic                  wready_ff;
    logic                  aw_full_ff;
    logic                  w_full_ff;
    logic [AXI_ADDR_W-1:0] awaddr_ff;
    logic [PORT_W-1:0]     wdata_ff;
    logic                  wstrb0_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  arready_ff;
    logic                  rvalid_ff;
    logic [AXI_DATA_W-1:0] rdata_ff;
    logic [1:0]            rresp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Pin read path
    logic [PORT_W-1:0] pin_read;
    assign pin_read = port_pin_in & ~analog_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel handshakes and decode
    logic aw_hs;
    logic w_hs;
    logic wr_fire;
    logic wr_hit_data;
    logic wr_hit_dir;
    logic wr_hit_latch;
    logic wr_hit_analog;
    logic wr_hit_ro;
    logic wr_mapped;
    logic [7:0] wr_ofs;
    logic [31:0] wr_addr_wide;
    logic wr_in_range;

    assign aw_hs         = s_axi_awvalid & awready_ff;
    assign w_hs          = s_axi_wvalid & wready_ff;
    // Both halves held and no response pending
    assign wr_fire       = aw_full_ff & w_full_ff & ~bvalid_ff;
    // Widened so the range test has upper bits at any address width
    assign wr_addr_wide  = 32'(awaddr_ff);
    assign wr_in_range   = (wr_addr_wide[31:8] == 24'h00_0000);
    assign wr_ofs        = {wr_addr_wide[7:2], 2'h0};
    assign wr_hit_data   = wr_in_range && (wr_ofs == OFS_PIN_DATA);
    assign wr_hit_dir    = wr_in_range && (wr_ofs == OFS_DIR);
    assign wr_hit_latch  = wr_in_range && (wr_ofs == OFS_LATCH);
    assign wr_hit_analog = wr_in_range && (wr_ofs == OFS_ANALOG);
    assign wr_hit_ro     = wr_in_range
                           && (wr_ofs == OFS_OWNED || wr_ofs == OFS_OWNER_IDX);
    assign wr_mapped     = wr_hit_data | wr_hit_dir | wr_hit_latch | wr_hit_analog | wr_hit_ro;

    ////////////////////////////////////////////////////////////////////////////
    // Next register values
    logic [PORT_W-1:0] nxt_dir;
    logic [PORT_W-1:0] nxt_latch;
    logic [PORT_W-1:0] nxt_analog;

    assign nxt_dir    = (wr_fire && wr_hit_dir && wstrb0_ff) ? wdata_ff : dir_ff;
    assign nxt_analog = (wr_fire && wr_hit_analog && wstrb0_ff) ? wdata_ff : analog_ff;
    // read-modify-write path
    // Lanes not strobed are refilled from the pins, so a port write with no
    // strobe still copies the pin levels into the latch
    assign nxt_latch  = (wr_fire && wr_hit_data) ? (wstrb0_ff ? wdata_ff : pin_read)
                      : (wr_fire && wr_hit_latch && wstrb0_ff) ? wdata_ff
                      : latch_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Output priority mux, one copy per pin
    logic [PORT_W-1:0] [SLOT_N-1:0] slot_mask;
    logic [PORT_W-1:0] [SLOT_IDX_W:0] pick;
    logic [PORT_W-1:0] nxt_pin_out;
    logic [PORT_W-1:0] nxt_pin_oe;
    logic [2*PORT_W-1:0] nxt_owner_idx;

    // Channel 3 slots vanish on the smaller package
    assign slot_mask = (VARIANT_28 == 1) ? (SLOT_MASK_BASE | SLOT_MASK_28) : SLOT_MASK_BASE;

    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        logic [SLOT_N-1:0] req;
        assign req = pin_funcs[i].en & slot_mask[i];
        assign pick[i] = prio_pick(req);
        assign nxt_pin_oe[i]  = pick[i][SLOT_IDX_W] ? pin_funcs[i].drv[pick[i][SLOT_IDX_W-1:0]]
                                                    : ~nxt_dir[i];
        assign nxt_pin_out[i] = pick[i][SLOT_IDX_W] ? pin_funcs[i].dat[pick[i][SLOT_IDX_W-1:0]]
                                                    : nxt_latch[i];
        assign nxt_owner_idx[2*i+1:2*i] = pick[i][SLOT_IDX_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel decode
    logic ar_hs;
    logic [7:0] rd_ofs;
    logic [31:0] rd_addr_wide;
    logic rd_in_range;
    logic rd_mapped;
    logic [PORT_W-1:0] rd_byte;
    logic [2*PORT_W-1:0] rd_half;
    logic [AXI_DATA_W-1:0] rd_word;

    assign ar_hs       = s_axi_arvalid & arready_ff;
    assign rd_addr_wide = 32'(s_axi_araddr);
    assign rd_ofs      = {rd_addr_wide[7:2], 2'h0};
    assign rd_in_range = (rd_addr_wide[31:8] == 24'h00_0000);
    assign rd_mapped   = rd_in_range && (rd_ofs == OFS_PIN_DATA || rd_ofs == OFS_DIR
                         || rd_ofs == OFS_LATCH || rd_ofs == OFS_ANALOG
                         || rd_ofs == OFS_OWNED || rd_ofs == OFS_OWNER_IDX);
    assign rd_byte     = (rd_ofs == OFS_PIN_DATA) ? pin_read
                       : (rd_ofs == OFS_DIR)      ? dir_ff
                       : (rd_ofs == OFS_LATCH)    ? latch_ff
                       : (rd_ofs == OFS_ANALOG)   ? analog_ff
                       : (rd_ofs == OFS_OWNED)    ? owned_ff
                       : 8'h00;
    assign rd_half     = (rd_ofs == OFS_OWNER_IDX) ? owner_idx_ff : {8'h00, rd_byte};
    // Upper bits read zero; unmapped words read zero with an error
    assign rd_word     = rd_mapped ? {16'h0000, rd_half} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Port registers
    // commit edge drives pins too
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_ff    <= DIR_RST;
            latch_ff  <= LATCH_RST;
            analog_ff <= ANALOG_RST;
        end else begin
            dir_ff    <= nxt_dir;
            latch_ff  <= nxt_latch;
            analog_ff <= nxt_analog;
        end
    end

    // Pin drive and status flops; peripheral changes reach the pin one edge later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_ff   <= LATCH_RST;
            pin_oe_ff    <= ~DIR_RST;
            owned_ff     <= 8'h00;
            owner_idx_ff <= 16'h0000;
        end else begin
            pin_out_ff   <= nxt_pin_out;
            pin_oe_ff    <= nxt_pin_oe;
            owned_ff     <= {pick[7][2], pick[6][2], pick[5][2], pick[4][2],
                             pick[3][2], pick[2][2], pick[1][2], pick[0][2]};
            owner_idx_ff <= nxt_owner_idx;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dig_in_ff <= 8'h00;
        end else begin
            dig_in_ff <= pin_read;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI write address and data capture, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'h0;
            awaddr_ff  <= '0;
        end else if (aw_hs) begin
            aw_full_ff <= 1'h1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_ff <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_ff <= 1'h0;
            wdata_ff  <= 8'h00;
            wstrb0_ff <= 1'h0;
        end else if (w_hs) begin
            w_full_ff <= 1'h1;
            wdata_ff  <= s_axi_wdata[PORT_W-1:0];
            wstrb0_ff <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full_ff <= 1'h0;
        end
    end

    // Ready only while the holding slot is empty; a slot never refills before it fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'h0;
            wready_ff  <= 1'h0;
        end else begin
            awready_ff <= ~(aw_hs | aw_full_ff) | wr_fire;
            wready_ff  <= ~(w_hs | w_full_ff) | wr_fire;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'h0;
            bresp_ff  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'h1;
            bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI read: data sampled at the address edge, one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'h0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_ff <= 1'h1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'h0;
        end
    end

    // Address ready drops while a read is taken or its data waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'h0;
        end else begin
            arready_ff <= ~ar_hs & (~rvalid_ff | s_axi_rready);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready    = awready_ff;
    assign s_axi_wready     = wready_ff;
    assign s_axi_bvalid     = bvalid_ff;
    assign s_axi_bresp      = bresp_ff;
    assign s_axi_arready    = arready_ff;
    assign s_axi_rvalid     = rvalid_ff;
    assign s_axi_rdata      = rdata_ff;
    assign s_axi_rresp      = rresp_ff;
    assign port_pin_out     = pin_out_ff;
    assign port_pin_oe      = pin_oe_ff;
    assign pin_digital_in   = dig_in_ff;
    assign pin_periph_owned = owned_ff;

endmodule

`default_nettype wire

// ### bench/bpm_port_sva.sv
// Concurrent checks on the bidirectional port's top-level ports
`timescale 1ns/10ps
`default_nettype none

module bpm_port_sva
    import bpm_pkg::*;
#(
    parameter int VARIANT_28 = 1
) (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic [1:0]                 s_axi_bresp,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic                       s_axi_rvalid,
    input wire bpm_pin_func_t [PORT_W-1:0] pin_funcs,
    input wire logic [PORT_W-1:0]          port_pin_in,
    input wire logic [PORT_W-1:0]          port_pin_out,
    input wire logic [PORT_W-1:0]          port_pin_oe,
    input wire logic [PORT_W-1:0]          pin_digital_in,
    input wire logic [PORT_W-1:0]          pin_periph_owned
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    // Bus timing; antecedents need a settled cycle after reset
    wr_commit_lat_a: assert property ($past(aresetn) && s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    rd_answer_lat_a: assert property ($past(aresetn) && s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response late");
    // Digital input path never shows a one the pad did not carry
    digin_follow_a: assert property ($past(aresetn)
        |-> (pin_digital_in & ~$past(port_pin_in)) == 8'h00) else $error("digital input not from pad");

    ////////////////////////////////////////////////////////////////////////////
    // Output priority; owner takes effect one edge after the request
    osc_in_release_a: assert property ($past(aresetn && pin_funcs[1].en[0] && !pin_funcs[1].drv[0])
        |-> !port_pin_oe[1] && pin_periph_owned[1]) else $error("oscillator input not released");
    lcd_seg_wins_a: assert property ($past(aresetn && pin_funcs[3].en[0] && pin_funcs[3].drv[0])
        |-> port_pin_oe[3] && port_pin_out[3] == $past(pin_funcs[3].dat[0])) else $error("segment lost pin");
    sck_only_a: assert property ($past(aresetn && pin_funcs[3].en == 4'h4 && pin_funcs[3].drv[2])
        |-> port_pin_out[3] == $past(pin_funcs[3].dat[2])) else $error("serial clock not driven");
    // Segment slot must be off, or it rightly wins over transmit
    tx_over_clk_a: assert property ($past(aresetn && pin_funcs[6].en[2:0] == 3'h6 && pin_funcs[6].drv[1])
        |-> port_pin_out[6] == $past(pin_funcs[6].dat[1])) else $error("transmit lost to clock");
    ch3_variant_a: assert property ($past(aresetn && pin_funcs[6].en == 4'h8)
        |-> pin_periph_owned[6] == (VARIANT_28 != 0)) else $error("channel 3 ownership wrong");
    latch_last_a: assert property ($past(aresetn && pin_funcs[0].en[1:0] == 2'h0)
        |-> !pin_periph_owned[0]) else $error("pin 0 owned with no request");

    // Main scenarios reached
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property (s_axi_rvalid);
    cover property (pin_periph_owned[6] && pin_periph_owned == 8'h40);
endmodule

bind bpm_port bpm_port_sva #(.VARIANT_28(VARIANT_28)) u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .pin_funcs(pin_funcs), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .pin_digital_in(pin_digital_in),
    .pin_periph_owned(pin_periph_owned));

`default_nettype wire

// ### bench/bpm_pad_model.sv
// Board-side pad model: resolves each pad from device drive and an external source
`timescale 1ns/10ps
`default_nettype none

module bpm_pad_model (
    input  wire logic       clk,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] out,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output var  logic [7:0] lvl
);
    logic [7:0] last_ff;

    // each pad alone; a floating pad toggles so a stale value never reads right
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl[i] = oe[i] ? out[i] : (ext_en[i] ? ext_val[i] : ~last_ff[i]);
        end
    end

    // Memory of the last level for floating pads
    always_ff @(posedge clk) begin
        last_ff <= lvl;
    end
endmodule

`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench: register access, pin drive, analog read and output priority
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import bpm_pkg::*;
();
    logic                       aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic                       awready, wready, bvalid, arready, rvalid;
    logic [7:0]                 awaddr, araddr, pin_lvl, pin_out, pin_oe, dig_in, owned, ext_en, ext_val;
    logic [31:0]                wdata, rdata;
    logic [3:0]                 wstrb;
    logic [1:0]                 bresp, rresp;
    bpm_pin_func_t [PORT_W-1:0] pin_funcs;
    int                         err_total, checked;

    bpm_port #(.AXI_ADDR_W(8), .VARIANT_28(1)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_funcs(pin_funcs), .port_pin_in(pin_lvl), .port_pin_out(pin_out),
        .port_pin_oe(pin_oe), .pin_digital_in(dig_in), .pin_periph_owned(owned));
    bpm_pad_model u_pad (.clk(aclk), .oe(pin_oe), .out(pin_out), .ext_en(ext_en), .ext_val(ext_val),
        .lvl(pin_lvl));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, compare and bus tasks
    task automatic summarize;
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tmo;
        err_total++;
        $display("MISMATCH bus_wait exp answer seen timeout");
        summarize();
    endtask
    // Ready lines are held high throughout, so responses are taken at the first valid edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) tmo();
        r = bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) tmo();
        d = rdata;
        r = rresp;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hF, r);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(nm, d, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rd_chk("dir_rst", OFS_DIR, 32'hFF);
        rd_chk("latch_rst", OFS_LATCH, 32'h0);
        rd_chk("analog_rst", OFS_ANALOG, 32'h0);
        chk("oe_rst", pin_oe, 8'h00);
    endtask
    // Upper nibble driven from the latch, lower nibble read from the board
    task automatic t_drive;
        ext_val <= 8'h3C;
        wr(OFS_LATCH, 32'hA5);
        wr(OFS_DIR, 32'h0F);
        chk("oe", pin_oe, 8'hF0);
        chk("out", pin_out, 8'hA5);
        rd_chk("pins", OFS_PIN_DATA, 32'hAC);
        chk("dig_in", dig_in, 8'hAC);
    endtask
    // Pin 7 analog while driven shows the driver stays on; pin 0 analog as input
    task automatic t_analog;
        logic [1:0] r;
        wr(OFS_ANALOG, 32'h81);
        chk("oe_ana", pin_oe, 8'hF0);
        rd_chk("pins_ana", OFS_PIN_DATA, 32'h2C);
        axi_wr(OFS_PIN_DATA, 32'hFF, 4'h0, r);
        rd_chk("rmw", OFS_LATCH, 32'h2C);
        wr(OFS_PIN_DATA, 32'h5A);
        rd_chk("wr_lat", OFS_LATCH, 32'h5A);
        chk("out_lat", pin_out, 8'h5A);
        wr(OFS_ANALOG, 32'h0);
        wr(OFS_DIR, 32'hFF);
    endtask
    task automatic t_errs;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(8'h20, 32'h1, 4'hF, r);
        chk("bresp_bad", r, RESP_SLVERR);
        rd_chk("dir_kept", OFS_DIR, 32'hFF);
        axi_rd(8'h20, d, r);
        chk("rresp_bad", r, RESP_SLVERR);
        chk("rdata_bad", d, 32'h0);
        axi_wr(OFS_OWNED, 32'hFF, 4'hF, r);
        chk("bresp_ro", r, RESP_OKAY);
        rd_chk("owned_ro", OFS_OWNED, 32'h0);
    endtask
    // Rows: pin, enable, drive, data, then expected {oe, out, owned}
    task automatic t_prio;
        logic [19:0] rows [14] = '{20'h13221, 20'h02227, 20'h03325, 20'h37765, 20'h36627, 20'h34447,
            20'h6EEA7, 20'h68887, 20'h76627, 20'h74405, 20'h23317, 20'h42205, 20'h52227, 20'h38880};
        bpm_pin_func_t [PORT_W-1:0] f;
        int p;
        wr(OFS_LATCH, 32'h0);
        foreach (rows[k]) begin
            p = int'(rows[k][19:16]);
            f = '0;
            f[p] = {rows[k][15:12], rows[k][11:8], rows[k][7:4]};
            pin_funcs <= f;
            @(posedge aclk);
            @(posedge aclk);
            chk("prio", {pin_oe[p], pin_out[p], owned[p]}, {29'h0, rows[k][2:0]});
        end
        // Two pins owned at once: serial clock on pin 3, channel 3 on pin 6
        f = '0;
        f[3] = {4'h4, 4'h4, 4'h0};
        f[6] = {4'h8, 4'h8, 4'h8};
        pin_funcs <= f;
        @(posedge aclk);
        @(posedge aclk);
        rd_chk("owner_idx", OFS_OWNER_IDX, 32'h3080);
        rd_chk("owned_map", OFS_OWNED, 32'h48);
        pin_funcs <= '0;
        @(posedge aclk);
        @(posedge aclk);
        chk("released", {owned, pin_oe}, 16'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
        {bready, rready, ext_en, ext_val} = {2'h3, 8'hFF, 8'h00};
        pin_funcs = '0;
        err_total = 0;
        checked = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_drive();
        t_analog();
        t_errs();
        t_prio();
        summarize();
    end
endmodule

`default_nettype wire
